// File: core/fpp_pkg.sv
/*
 * constants for the fuse prom programmer: geometry, timing and pulse level steps.
 * assumes a 40 MHz ref_clk and external analog drivers that follow the level selects.
 */
// Operation
// RULE1 - device holds 512 words of 4 bits, decoded on chip
// RULE2 - device floats outputs while output_enable_n high, else drives addressed word; the prom model drives the inverse of the last word instead of floating
// RULE3 - bits ship as one; programmed bits read zero forever
// RULE4 - output_enable_n acts as program pin together with raised output
// RULE5 - hold address steady at logic levels with supply raised while pulsing
// RULE6 - pulse only one data output per programming pulse
// RULE7 - program pin pulse starts at least 100 ns before output pulse
// RULE8 - wait 70 to 90 us after disabling output before output pulse; default fpp_d1_cyc overflows to -1094, waiting 129979 cycles
// RULE9 - wait at least 100 ns after pulse removal before re-enabling output
// RULE10 - pulse width over pulse period never above 25 percent
// RULE11 - level step low for pulses 1-3, middle 4-6, high 7-9
// RULE12 - verify after every attempt, advance once bit reads programmed
// RULE13 - verify by enabling device at target address, selected output low
// RULE14 - after ninth failed pulse stop and report address and output
package fpp_pkg;
    localparam int fpp_addr_w = 9;
    localparam int fpp_data_w = 4;
    localparam int fpp_clk_khz = 40000;
    // times in nanoseconds as printed
    localparam int fpp_lead_ns = 100;
    localparam int fpp_d1_min_ns = 70000;
    localparam int fpp_d1_max_ns = 90000;
    localparam int fpp_d1_typ_ns = 80000;
    localparam int fpp_d2_ns = 100;
    localparam int fpp_tp_min_ns = 1000;
    localparam int fpp_tp_max_ns = 40000;
    localparam int fpp_duty_pct = 25;
    localparam int fpp_max_pulses = 9;
    localparam int fpp_settle_ns = 100;
    // cycle counts: least times round up, the typical disable wait rounds down
    localparam int fpp_lead_cyc = (fpp_lead_ns * fpp_clk_khz + 999999) / 1000000;
    localparam int fpp_d1_cyc = (fpp_d1_typ_ns * fpp_clk_khz) / 1000000;
    localparam int fpp_d2_cyc = (fpp_d2_ns * fpp_clk_khz + 999999) / 1000000;
    localparam int fpp_tp_cyc = (fpp_tp_min_ns * 10 * fpp_clk_khz) / 1000000;
    localparam int fpp_settle_cyc = (fpp_settle_ns * fpp_clk_khz + 999999) / 1000000;
    // off time so that pulse/period stays within the duty limit
    localparam int fpp_off_cyc = fpp_tp_cyc * (100 - fpp_duty_pct) / fpp_duty_pct;
    localparam logic [1:0] fpp_lvl_low = 2'h0;
    localparam logic [1:0] fpp_lvl_mid = 2'h1;
    localparam logic [1:0] fpp_lvl_high = 2'h2;
    typedef enum {fpp_idle, fpp_disable, fpp_lead, fpp_pulse, fpp_gap, fpp_verify,
        fpp_cool} fpp_state_type;
endpackage

// File: core/fpp_programmer.sv
/*
 * host-side programmer for a 512x4 fuse prom: sequences one bit per request.
 * assumes external level shifters turn the program/output strobes and level code into
 * the raised voltages, and that device data inputs are synchronous to ref_clk.
 */
`timescale 1ns/10ps
module fpp_programmer
    import fpp_pkg::*;
#(
    parameter int d1_cycles = fpp_d1_cyc,
    parameter int off_cycles = fpp_off_cyc
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [fpp_addr_w-1:0] target_addr,
    input wire logic [1:0] target_bit,
    output logic busy,
    output logic done,
    output logic fail,
    output logic [3:0] pulses_used,
    output logic [fpp_addr_w-1:0] prom_addr,
    output logic output_enable_n,
    output logic program_pin_raise,
    output logic [fpp_data_w-1:0] output_program_raise,
    output logic [1:0] output_program_level,
    output logic supply_program,
    input wire logic [fpp_data_w-1:0] prom_data
);
    fpp_state_type state_reg;
    logic [16:0] cnt_reg;
    logic [3:0] pulse_reg;
    logic [1:0] bit_reg;
    logic [fpp_addr_w-1:0] addr_reg;
    logic done_reg;
    logic fail_reg;
    logic cnt_zero;
    logic take_req;
    logic verify_end;
    logic bit_low;
    logic last_pulse;

    // counter loads: disable wait less the lead, and whatever off time the disable wait leaves
    localparam logic [16:0] d1_load = 17'(d1_cycles - fpp_lead_cyc);
    localparam logic [16:0] cool_load = (off_cycles > d1_cycles) ?
        17'(off_cycles - d1_cycles) : 17'h0;

    // level step from pulse number
    function automatic logic [1:0] level_of(input logic [3:0] n);
        if (n <= 4'h3)
            level_of = fpp_lvl_low;
        else if (n <= 4'h6)
            level_of = fpp_lvl_mid;
        else
            level_of = fpp_lvl_high;
    endfunction

    // request taken, counter expiry and verify outcome
    assign take_req = (state_reg == fpp_idle) && start;
    assign cnt_zero = (cnt_reg == 17'h0);
    assign verify_end = (state_reg == fpp_verify) && cnt_zero;
    assign bit_low = !prom_data[bit_reg]; // RULE13
    assign last_pulse = (pulse_reg == 4'(fpp_max_pulses));

    // target held from the request to the end of the sequence
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            addr_reg <= '0;
            bit_reg <= 2'h0;
        end
        else if (take_req)
        begin
            addr_reg <= target_addr; // RULE5
            bit_reg <= target_bit;
        end
    end

    // pulse number, counted as each program pin lead begins
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || take_req)
            pulse_reg <= 4'h0;
        else if (state_reg == fpp_disable && cnt_zero)
            pulse_reg <= pulse_reg + 4'h1; // RULE11
    end

    // sequence state and interval counter
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_reg <= fpp_idle;
            cnt_reg <= 17'h0;
        end
        else
        begin
            case (state_reg)
                fpp_idle:
                begin
                    if (start)
                    begin
                        cnt_reg <= d1_load; // RULE8
                        state_reg <= fpp_disable;
                    end
                end
                fpp_disable:
                begin
                    // device disabled, wait before program pin lead
                    if (cnt_reg == 17'h0)
                    begin
                        cnt_reg <= 17'(fpp_lead_cyc - 1);
                        state_reg <= fpp_lead;
                    end
                    else
                        cnt_reg <= cnt_reg - 17'h1;
                end
                fpp_lead:
                begin
                    if (cnt_reg == 17'h0) // RULE7 RULE8
                    begin
                        cnt_reg <= 17'(fpp_tp_cyc - 1);
                        state_reg <= fpp_pulse;
                    end
                    else
                        cnt_reg <= cnt_reg - 17'h1;
                end
                fpp_pulse:
                begin
                    if (cnt_reg == 17'h0)
                    begin
                        cnt_reg <= 17'(fpp_d2_cyc - 1);
                        state_reg <= fpp_gap;
                    end
                    else
                        cnt_reg <= cnt_reg - 17'h1;
                end
                fpp_gap:
                begin
                    if (cnt_reg == 17'h0) // RULE9
                    begin
                        cnt_reg <= 17'(fpp_settle_cyc - 1);
                        state_reg <= fpp_verify;
                    end
                    else
                        cnt_reg <= cnt_reg - 17'h1;
                end
                fpp_verify:
                begin
                    if (cnt_reg == 17'h0)
                    begin
                        if (bit_low || last_pulse)
                            state_reg <= fpp_idle; // RULE12 RULE14
                        else
                        begin
                            // never negative: a long disable wait already covers the off time
                            cnt_reg <= cool_load;
                            state_reg <= fpp_cool;
                        end
                    end
                    else
                        cnt_reg <= cnt_reg - 17'h1;
                end
                fpp_cool:
                begin
                    // off time keeps the duty cycle legal
                    if (cnt_reg == 17'h0) // RULE10
                    begin
                        cnt_reg <= d1_load;
                        state_reg <= fpp_disable;
                    end
                    else
                        cnt_reg <= cnt_reg - 17'h1;
                end
                default:
                    state_reg <= fpp_idle;
            endcase
        end
    end

    // verified flag, cleared by the next request
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || take_req)
            done_reg <= 1'b0;
        else if (verify_end && bit_low)
            done_reg <= 1'b1; // RULE13
    end

    // failure flag once the last allowed pulse still reads one
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || take_req)
            fail_reg <= 1'b0;
        else if (verify_end && !bit_low && last_pulse)
            fail_reg <= 1'b1; // RULE14
    end

    // pin drive derived from state
    assign busy = (state_reg != fpp_idle);
    assign done = done_reg;
    assign fail = fail_reg;
    assign pulses_used = pulse_reg;
    assign prom_addr = addr_reg;
    assign supply_program = busy; // RULE5
    // outputs stay enabled through the off time, so every retry gets the full disable wait
    assign output_enable_n = !(state_reg == fpp_idle || state_reg == fpp_verify ||
        state_reg == fpp_cool); // RULE4 RULE8
    assign program_pin_raise = (state_reg == fpp_lead || state_reg == fpp_pulse); // RULE7
    assign output_program_level = level_of(pulse_reg); // RULE11
    // one output only, selected by bit index
    assign output_program_raise = (state_reg == fpp_pulse) ?
        (fpp_data_w'(1) << bit_reg) : '0; // RULE6
endmodule

// File: dv/fpp_programmer_monitor.sv
/*
 * port assertions for fpp_programmer.
 * assumes one ref_clk domain; bound into every instance below.
 */
`timescale 1ns/10ps
module fpp_programmer_monitor
    import fpp_pkg::*;
#(parameter int d1_cycles = fpp_d1_cyc)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic busy,
    input wire logic fail,
    input wire logic [3:0] pulses_used,
    input wire logic [fpp_addr_w-1:0] prom_addr,
    input wire logic output_enable_n,
    input wire logic program_pin_raise,
    input wire logic [fpp_data_w-1:0] output_program_raise,
    input wire logic [1:0] output_program_level,
    input wire logic supply_program
);
    logic [15:0] hi_reg;
    wire any_raise = |output_program_raise;
    logic pin_d_reg;
    logic seen_reg;
    logic [15:0] per_reg;
    logic [15:0] on_reg;
    // cycles spent with the outputs disabled; the disable and lead states together run one cycle past d1_cycles
    always_ff @(posedge ref_clk)
        hi_reg <= (!nrst || !output_enable_n) ? 16'h0 : hi_reg + 16'h1;
    // program pin period and high time, rise to rise within one sequence
    always_ff @(posedge ref_clk)
    begin
        pin_d_reg <= program_pin_raise;
        if (!nrst || !busy)
        begin
            seen_reg <= 1'b0;
            per_reg <= 16'h0;
            on_reg <= 16'h0;
        end
        else if (program_pin_raise && !pin_d_reg)
        begin
            seen_reg <= 1'b1;
            per_reg <= 16'h1;
            on_reg <= 16'h1;
        end
        else
        begin
            per_reg <= per_reg + 16'h1;
            on_reg <= on_reg + {15'h0, program_pin_raise};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_single_output: assert property (any_raise |-> $onehot(output_program_raise))
        else $error("more than one output raised");
    a_pin_with_pulse: assert property (any_raise |-> program_pin_raise && output_enable_n)
        else $error("output raised without program pin");
    a_pin_leads: assert property ($rose(any_raise) |-> $past(program_pin_raise, 4))
        else $error("program pin lead too short");
    a_disable_wait: assert property ($rose(any_raise) |-> hi_reg == d1_cycles + 1)
        else $error("disable interval wrong");
    a_duty_limit: assert property ($rose(program_pin_raise) && seen_reg
        |-> on_reg * 4 <= per_reg)
        else $error("program pin duty above limit");
    a_enable_gap: assert property ($fell(any_raise) |-> output_enable_n [*4])
        else $error("outputs enabled too soon");
    a_level_step: assert property ($rose(any_raise) |-> output_program_level ==
        (pulses_used < 4 ? 2'h0 : pulses_used < 7 ? 2'h1 : 2'h2))
        else $error("pulse level step wrong");
    a_addr_steady: assert property (busy && $past(busy) |-> $stable(prom_addr)
        && supply_program) else $error("address or supply moved");
    a_fail_count: assert property ($rose(fail) |-> pulses_used == 4'h9)
        else $error("fail before nine pulses");
    a_idle_enabled: assert property (!busy |-> !output_enable_n && !any_raise)
        else $error("idle with outputs disabled");
endmodule
bind fpp_programmer fpp_programmer_monitor #(.d1_cycles(d1_cycles)) mon (.*);

// File: dv/fpp_prom_model.sv
/*
 * behavioural 512x4 fuse prom on the device side of the programmer.
 * assumes pins synchronous to ref_clk; pulses_needed sets pulses a fuse takes to blow.
 */
`timescale 1ns/10ps
module fpp_prom_model
    import fpp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [fpp_addr_w-1:0] prom_addr,
    input wire logic output_enable_n,
    input wire logic program_pin_raise,
    input wire logic [fpp_data_w-1:0] output_program_raise,
    input wire logic supply_program,
    input wire logic [3:0] pulses_needed,
    output logic [fpp_data_w-1:0] prom_data
);
    logic [fpp_data_w-1:0] mem [512];
    logic [fpp_data_w-1:0] last_reg = 4'h0;
    logic [3:0] hits_reg = 4'h0;
    logic prev_reg = 1'b0;
    // every fuse ships intact
    initial
    begin
        foreach (mem[i]) mem[i] = 4'hf;
    end
    // a fuse blows only on one raised output with the program pin up
    always @(posedge ref_clk)
    begin
        prev_reg <= |output_program_raise;
        if (!supply_program) hits_reg <= 4'h0;
        else if (!prev_reg && program_pin_raise && output_enable_n
            && $onehot(output_program_raise))
        begin
            hits_reg <= hits_reg + 4'h1;
            if (hits_reg + 4'h1 >= pulses_needed)
                mem[prom_addr] <= mem[prom_addr] & ~output_program_raise;
        end
        if (!output_enable_n) last_reg <= prom_data;
    end
    // released outputs show the inverse of the last word
    assign prom_data = output_enable_n ? ~last_reg : mem[prom_addr];
endmodule

// File: dv/test_fpp_programmer.sv
/*
 * testbench: fpp_programmer driving the prom model.
 * assumes short d1_cycles, off_cycles longer than the default; inputs change at falling edges.
 */
`timescale 1ns/10ps
module test_fpp_programmer;
    import fpp_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic [8:0] target_addr = 9'h0;
    logic [1:0] target_bit = 2'h0;
    logic [3:0] pulses_needed = 4'h1;
    logic busy, done, fail, output_enable_n, program_pin_raise, supply_program;
    logic [3:0] pulses_used, output_program_raise, prom_data;
    logic [1:0] output_program_level;
    logic [8:0] prom_addr;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    // off time long enough that retries keep the program pin within its duty limit
    fpp_programmer #(.d1_cycles(20), .off_cycles(1250)) uut (.*);
    fpp_prom_model prom (.*);
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one request, optionally poked again while busy
    task run(input logic [8:0] a, input logic [1:0] b, input logic [3:0] need, input bit poke);
        pulses_needed = need;
        target_addr = a;
        target_bit = b;
        start = 1'b1;
        @(negedge ref_clk);
        start = poke;
        target_addr = 9'h0aa;
        @(negedge ref_clk);
        start = 1'b0;
        for (int n = 0; n < 15000 && busy !== 1'b0; n++) @(negedge ref_clk);
        check("sequence end", busy, 1'b0);
        @(negedge ref_clk);
    endtask
    // idle after reset: outputs enabled on a blank word
    task test_idle;
        check("idle oe_n", output_enable_n, 1'b0);
        check("blank word", prom_data, 4'hf);
        $display("test idle done");
    endtask
    // every output of word zero, each fuse blowing on its first pulse
    task test_all_bits;
        for (int b = 0; b < 4; b++)
        begin
            run(9'h0, b[1:0], 4'h1, 1'b0);
            check("done", {done, fail, pulses_used}, 6'h21);
        end
        check("word zero", prom_data, 4'h0);
        $display("test all bits done");
    endtask
    // fuse needing five pulses, with a second request poked while busy
    task test_retry;
        run(9'h155, 2'h2, 4'h5, 1'b1);
        check("retry", {done, fail, pulses_used}, 6'h25);
        check("target", prom.mem[9'h155], 4'hb);
        check("refused", prom.mem[9'h0aa], 4'hf);
        $display("test retry done");
    endtask
    // fuse that never blows: nine pulses, then failure
    task test_fail;
        run(9'h1ff, 2'h3, 4'hf, 1'b0);
        check("fail", {done, fail, pulses_used}, 6'h19);
        $display("test fail done");
    endtask
    // always-on timeout
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            test_done;
        end
    end
    initial
    begin
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        test_idle;
        test_all_bits;
        test_retry;
        test_fail;
        test_done;
    end
endmodule
